// [core/bca_calendar_alarm_regs.sv]
// Purpose: BCD clock, calendar and two alarms behind an I2C slave register map.
// Assumes: Host is an I2C master; scl and sda arrive asynchronously.
// Notes: Temperature bytes read as zero; no sensor lives in this core.
// What this block does
// - Time and calendar registers hold BCD digits, read and written by byte.
// - Hours bit 6 selects format: one is 12-hour, zero is 24-hour.
// - In 12-hour format hours bit 5 marks afternoon when set.
// - In 24-hour format hours bit 5 is the tens digit two.
// - Century bit in month bit 7 flips when year wraps 99 to 00.
// - Weekday advances at midnight, cycling one through seven.
// - Shadow copy taken on START and pointer wrap; time reads use the shadow, other registers read live.
// - Writing seconds restarts the sub-second counter from zero.
// - A written byte lands in its register at the device's acknowledge.
// - Alarm one uses addresses 07h to 0Ah, alarm two 0Bh to 0Dh.
// - Bit 7 of each alarm byte masks it; unmasked fields must all match.
// - Alarm day byte bit 6 chooses weekday over day of month.
// - Alarm one masks give every second up to full date match.
// - Alarm two has no seconds; all masked fires at 00 seconds.
// - Match sets the flag; output asserts only with enable and select.
// - Alarms are compared only at the once-per-second update.
// - Pointer auto-increments and wraps from 12h to 00h.
// - Month end rolls over for short months and leap February.
`timescale 1ns/1ps
`default_nettype none
module bca_calendar_alarm_regs #(
	parameter logic [6:0] SLAVE_ADDR = 7'h5A, // Arbitrary value.
	parameter int SUBSEC_CYCLES = bca_pkg::SUBSEC_CYCLES
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_o,
	output logic sda_oe,
	output logic irq_square_output_n
);
	localparam int SUB_W = $clog2(SUBSEC_CYCLES);

	function automatic logic [8:0] bcd_step(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		logic [8:0] r;
		r = {1'b0, v};
		if (v == last) begin
			r = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	// Leap test on the BCD year alone; century years are not special.
	function automatic logic [7:0] month_last(input logic [7:0] m,
		input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		if (m == 8'h02) begin
			return leap ? 8'h29 : 8'h28;
		end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
			return 8'h30;
		end
		return 8'h31;
	endfunction

	function automatic logic [4:0] next_ptr(input logic [4:0] p);
		return (p >= bca_pkg::ADDR_LAST) ? 5'h00 : p + 5'h01;
	endfunction

	function automatic logic day_match(input logic [7:0] a,
		input bca_pkg::bca_time_t t);
		if (a[bca_pkg::ALARM_DYDT_BIT]) begin
			return t.wday[3:0] == a[3:0];
		end
		return t.date[5:0] == a[5:0];
	endfunction

	bca_pkg::bca_time_t live;
	bca_pkg::bca_time_t shadow;
	bca_pkg::bca_time_t next_time;
	bca_pkg::bca_time_t next_live;
	bca_pkg::bca_state_t state;
	logic [7:0] a1_sec, a1_min, a1_hour, a1_day;
	logic [7:0] a2_min, a2_hour, a2_day;
	logic [7:0] ctrl, aging;
	logic osc_halted_flag, en32, a1f, a2f;
	logic [SUB_W-1:0] subsec;
	logic tick, tick_d, square;
	logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
	logic rise, fall, start, stop;
	logic [2:0] bitcnt;
	logic [7:0] shreg, tx, rd_byte;
	logic got, rnw, expect_ptr, snap;
	logic [4:0] ptr;
	logic wr_pulse;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;
	logic a1_hit, a2_hit, stat_wr;

	// Both pins pass three flops; edge logic compares the second flop with the third.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_q <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s1 <= scl_in;
			scl_s2 <= scl_s1;
			scl_q <= scl_s2;
			sda_s1 <= sda_in;
			sda_s2 <= sda_s1;
			sda_q <= sda_s2;
		end
	end

	assign rise = scl_s2 & ~scl_q;
	assign fall = ~scl_s2 & scl_q;
	assign start = scl_s2 & scl_q & sda_q & ~sda_s2;
	assign stop = scl_s2 & scl_q & ~sda_q & sda_s2;

	always_comb begin
		rd_byte = 8'h00;
		if (ptr == bca_pkg::ADDR_SEC) begin
			rd_byte = shadow.sec;
		end else if (ptr == bca_pkg::ADDR_MIN) begin
			rd_byte = shadow.min;
		end else if (ptr == bca_pkg::ADDR_HOUR) begin
			rd_byte = shadow.hour;
		end else if (ptr == bca_pkg::ADDR_WDAY) begin
			rd_byte = shadow.wday;
		end else if (ptr == bca_pkg::ADDR_DATE) begin
			rd_byte = shadow.date;
		end else if (ptr == bca_pkg::ADDR_MONTH) begin
			rd_byte = shadow.month;
		end else if (ptr == bca_pkg::ADDR_YEAR) begin
			rd_byte = shadow.year;
		end else if (ptr == bca_pkg::ADDR_A1_SEC) begin
			rd_byte = a1_sec;
		end else if (ptr == bca_pkg::ADDR_A1_MIN) begin
			rd_byte = a1_min;
		end else if (ptr == bca_pkg::ADDR_A1_HOUR) begin
			rd_byte = a1_hour;
		end else if (ptr == bca_pkg::ADDR_A1_DAY) begin
			rd_byte = a1_day;
		end else if (ptr == bca_pkg::ADDR_A2_MIN) begin
			rd_byte = a2_min;
		end else if (ptr == bca_pkg::ADDR_A2_HOUR) begin
			rd_byte = a2_hour;
		end else if (ptr == bca_pkg::ADDR_A2_DAY) begin
			rd_byte = a2_day;
		end else if (ptr == bca_pkg::ADDR_CTRL) begin
			rd_byte = ctrl;
		end else if (ptr == bca_pkg::ADDR_STAT) begin
			rd_byte = {osc_halted_flag, 3'b000, en32, 1'b0, a2f, a1f};
		end else if (ptr == bca_pkg::ADDR_AGING) begin
			rd_byte = aging;
		end
	end

	// Slave state machine; no clock stretching, so the host sets the pace.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= bca_pkg::ST_IDLE;
			bitcnt <= 3'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			got <= 1'b0;
			rnw <= 1'b0;
			expect_ptr <= 1'b0;
			ptr <= 5'h00;
			sda_oe <= 1'b0;
			snap <= 1'b0;
			wr_pulse <= 1'b0;
			wr_addr <= 5'h00;
			wr_data <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			snap <= 1'b0;
			if (start) begin
				state <= bca_pkg::ST_ADDR;
				bitcnt <= 3'h0;
				got <= 1'b0;
				sda_oe <= 1'b0;
				snap <= 1'b1;
			end else if (stop) begin
				state <= bca_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					bca_pkg::ST_ADDR, bca_pkg::ST_WR: begin
						if (rise) begin
							shreg <= {shreg[6:0], sda_s2};
							bitcnt <= bitcnt + 3'h1;
							got <= (bitcnt == 3'h7);
						end else if (fall && got) begin
							got <= 1'b0;
							if (state == bca_pkg::ST_ADDR) begin
								if (shreg[7:1] == SLAVE_ADDR) begin
									sda_oe <= 1'b1;
									rnw <= shreg[0];
									state <= bca_pkg::ST_ACK_ADDR;
								end else begin
									state <= bca_pkg::ST_IDLE;
								end
							end else begin
								sda_oe <= 1'b1;
								state <= bca_pkg::ST_ACK_WR;
								if (expect_ptr) begin
									ptr <= shreg[4:0];
									expect_ptr <= 1'b0;
								end else begin
									wr_pulse <= 1'b1;
									wr_addr <= ptr;
									wr_data <= shreg;
									ptr <= next_ptr(ptr);
									snap <= (next_ptr(ptr) == 5'h00);
								end
							end
						end
					end
					bca_pkg::ST_ACK_ADDR: begin
						if (fall) begin
							if (rnw) begin
								sda_oe <= ~rd_byte[7];
								tx <= {rd_byte[6:0], 1'b0};
								ptr <= next_ptr(ptr);
								snap <= (next_ptr(ptr) == 5'h00);
								state <= bca_pkg::ST_RD;
							end else begin
								sda_oe <= 1'b0;
								expect_ptr <= 1'b1;
								state <= bca_pkg::ST_WR;
							end
						end
					end
					bca_pkg::ST_ACK_WR: begin
						if (fall) begin
							sda_oe <= 1'b0;
							state <= bca_pkg::ST_WR;
						end
					end
					bca_pkg::ST_RD: begin
						if (rise) begin
							bitcnt <= bitcnt + 3'h1;
							got <= (bitcnt == 3'h7);
						end else if (fall) begin
							if (got) begin
								got <= 1'b0;
								sda_oe <= 1'b0;
								state <= bca_pkg::ST_ACK_RD;
							end else begin
								sda_oe <= ~tx[7];
								tx <= {tx[6:0], 1'b0};
							end
						end
					end
					bca_pkg::ST_ACK_RD: begin
						if (rise && sda_s2) begin
							state <= bca_pkg::ST_IDLE;
						end else if (fall) begin
							sda_oe <= ~rd_byte[7];
							tx <= {rd_byte[6:0], 1'b0};
							ptr <= next_ptr(ptr);
							snap <= (next_ptr(ptr) == 5'h00);
							state <= bca_pkg::ST_RD;
						end
					end
					default: begin
						state <= bca_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// The pin only ever pulls low, so the driven level is a constant zero.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shadow <= bca_pkg::TIME_RESET;
		end else if (snap) begin
			shadow <= live;
		end
	end

	// A seconds write restarts the second, so the tick cannot land mid-setting.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			subsec <= '0;
			tick <= 1'b0;
			tick_d <= 1'b0;
			square <= 1'b1;
		end else begin
			tick_d <= tick;
			square <= (subsec < SUB_W'(SUBSEC_CYCLES / 2));
			if (wr_pulse && wr_addr == bca_pkg::ADDR_SEC) begin
				subsec <= '0;
				tick <= 1'b0;
			end else if (subsec == SUB_W'(SUBSEC_CYCLES - 1)) begin
				subsec <= '0;
				tick <= 1'b1;
			end else begin
				subsec <= subsec + SUB_W'(1);
				tick <= 1'b0;
			end
		end
	end

	always_comb begin
		logic [8:0] s;
		logic [8:0] m;
		logic [8:0] h;
		logic [8:0] d;
		logic [8:0] mo;
		logic [8:0] y;
		logic midnight;
		h = 9'h000;
		s = bcd_step(live.sec, 8'h59, 8'h00);
		m = bcd_step(live.min, 8'h59, 8'h00);
		d = bcd_step(live.date, month_last(live.month & 8'h1F, live.year), 8'h01);
		mo = bcd_step(live.month & 8'h1F, 8'h12, 8'h01);
		y = bcd_step(live.year, 8'h99, 8'h00);
		midnight = 1'b0;
		next_time = live;
		next_time.sec = s[7:0];
		if (s[8]) begin
			next_time.min = m[7:0];
			if (m[8]) begin
				if (live.hour[bca_pkg::HOUR_12H_BIT]) begin
					h = bcd_step({3'b000, live.hour[4:0]}, 8'h12, 8'h01);
					next_time.hour[4:0] = h[4:0];
					if (live.hour[4:0] == 5'h11) begin
						next_time.hour[bca_pkg::HOUR_PM_BIT] = ~live.hour[bca_pkg::HOUR_PM_BIT];
						midnight = live.hour[bca_pkg::HOUR_PM_BIT];
					end
				end else begin
					h = bcd_step({2'b00, live.hour[5:0]}, 8'h23, 8'h00);
					next_time.hour[5:0] = h[5:0];
					midnight = h[8];
				end
				if (midnight) begin
					next_time.wday = (live.wday == 8'h07) ? 8'h01 : live.wday + 8'h01;
					next_time.date = d[7:0];
					if (d[8]) begin
						next_time.month[4:0] = mo[4:0];
						if (mo[8]) begin
							next_time.year = y[7:0];
							if (y[8]) begin
								next_time.month[bca_pkg::MONTH_CENTURY_BIT] =
									~live.month[bca_pkg::MONTH_CENTURY_BIT];
							end
						end
					end
				end
			end
		end
	end

	// A write in the tick cycle keeps the rest of that second's carry.
	always_comb begin
		next_live = tick ? next_time : live;
		if (wr_pulse) begin
			if (wr_addr == bca_pkg::ADDR_SEC) begin
				next_live.sec = wr_data & bca_pkg::MASK_SEC;
			end else if (wr_addr == bca_pkg::ADDR_MIN) begin
				next_live.min = wr_data & bca_pkg::MASK_SEC;
			end else if (wr_addr == bca_pkg::ADDR_HOUR) begin
				next_live.hour = wr_data & bca_pkg::MASK_HOUR;
			end else if (wr_addr == bca_pkg::ADDR_WDAY) begin
				next_live.wday = wr_data & bca_pkg::MASK_WDAY;
			end else if (wr_addr == bca_pkg::ADDR_DATE) begin
				next_live.date = wr_data & bca_pkg::MASK_DATE;
			end else if (wr_addr == bca_pkg::ADDR_MONTH) begin
				next_live.month = wr_data & bca_pkg::MASK_MONTH;
			end else if (wr_addr == bca_pkg::ADDR_YEAR) begin
				next_live.year = wr_data;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			live <= bca_pkg::TIME_RESET;
		end else begin
			live <= next_live;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			a1_sec <= bca_pkg::ALARM_RESET;
			a1_min <= bca_pkg::ALARM_RESET;
			a1_hour <= bca_pkg::ALARM_RESET;
			a1_day <= bca_pkg::ALARM_RESET;
			a2_min <= bca_pkg::ALARM_RESET;
			a2_hour <= bca_pkg::ALARM_RESET;
			a2_day <= bca_pkg::ALARM_RESET;
			ctrl <= bca_pkg::CTRL_RESET;
			aging <= bca_pkg::AGING_RESET;
		end else if (wr_pulse) begin
			if (wr_addr == bca_pkg::ADDR_A1_SEC) begin
				a1_sec <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A1_MIN) begin
				a1_min <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A1_HOUR) begin
				a1_hour <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A1_DAY) begin
				a1_day <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A2_MIN) begin
				a2_min <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A2_HOUR) begin
				a2_hour <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_A2_DAY) begin
				a2_day <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_CTRL) begin
				ctrl <= wr_data;
			end else if (wr_addr == bca_pkg::ADDR_AGING) begin
				aging <= wr_data;
			end
		end
	end

	// Compared one cycle after the tick, against the freshly updated time.
	assign a1_hit = tick_d
		& (a1_sec[bca_pkg::ALARM_MASK_BIT] | live.sec[6:0] == a1_sec[6:0])
		& (a1_min[bca_pkg::ALARM_MASK_BIT] | live.min[6:0] == a1_min[6:0])
		& (a1_hour[bca_pkg::ALARM_MASK_BIT] | live.hour[6:0] == a1_hour[6:0])
		& (a1_day[bca_pkg::ALARM_MASK_BIT] | day_match(a1_day, live));
	assign a2_hit = tick_d
		& (live.sec == 8'h00)
		& (a2_min[bca_pkg::ALARM_MASK_BIT] | live.min[6:0] == a2_min[6:0])
		& (a2_hour[bca_pkg::ALARM_MASK_BIT] | live.hour[6:0] == a2_hour[6:0])
		& (a2_day[bca_pkg::ALARM_MASK_BIT] | day_match(a2_day, live));
	assign stat_wr = wr_pulse && wr_addr == bca_pkg::ADDR_STAT;

	// Writing one to a flag leaves it alone; a match in the clear cycle wins.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			osc_halted_flag <= 1'b1;
			en32 <= 1'b1;
			a1f <= 1'b0;
			a2f <= 1'b0;
		end else begin
			a1f <= a1_hit | (a1f & ~(stat_wr & ~wr_data[bca_pkg::STAT_A1F_BIT]));
			a2f <= a2_hit | (a2f & ~(stat_wr & ~wr_data[bca_pkg::STAT_A2F_BIT]));
			if (stat_wr) begin
				osc_halted_flag <= osc_halted_flag & wr_data[bca_pkg::STAT_OSF_BIT];
				en32 <= wr_data[bca_pkg::STAT_EN32_BIT];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_square_output_n <= 1'b1;
		end else if (ctrl[bca_pkg::CTRL_IRQ_OR_SQUARE_SELECT_BIT]) begin
			irq_square_output_n <= ~((a1f & ctrl[bca_pkg::CTRL_FIRST_ALARM_IRQ_ENABLE_BIT])
				| (a2f & ctrl[bca_pkg::CTRL_SECOND_ALARM_IRQ_ENABLE_BIT]));
		end else begin
			irq_square_output_n <= square;
		end
	end
endmodule // bca_calendar_alarm_regs
`default_nettype wire

// [core/bca_pkg.sv]
// Purpose: Shared constants and types for the BCD calendar and alarm core.
// Assumes: 20 MHz system clock, byte-wide register map reached over I2C.
// Notes: All offsets and field positions live here, and every reset value except the status flags', which reset in the core.
package bca_pkg;
	localparam logic [4:0] ADDR_SEC = 5'h00;
	localparam logic [4:0] ADDR_MIN = 5'h01;
	localparam logic [4:0] ADDR_HOUR = 5'h02;
	localparam logic [4:0] ADDR_WDAY = 5'h03;
	localparam logic [4:0] ADDR_DATE = 5'h04;
	localparam logic [4:0] ADDR_MONTH = 5'h05;
	localparam logic [4:0] ADDR_YEAR = 5'h06;
	localparam logic [4:0] ADDR_A1_SEC = 5'h07;
	localparam logic [4:0] ADDR_A1_MIN = 5'h08;
	localparam logic [4:0] ADDR_A1_HOUR = 5'h09;
	localparam logic [4:0] ADDR_A1_DAY = 5'h0A;
	localparam logic [4:0] ADDR_A2_MIN = 5'h0B;
	localparam logic [4:0] ADDR_A2_HOUR = 5'h0C;
	localparam logic [4:0] ADDR_A2_DAY = 5'h0D;
	localparam logic [4:0] ADDR_CTRL = 5'h0E;
	localparam logic [4:0] ADDR_STAT = 5'h0F;
	localparam logic [4:0] ADDR_AGING = 5'h10;
	localparam logic [4:0] ADDR_TEMP_HI = 5'h11;
	localparam logic [4:0] ADDR_TEMP_LO = 5'h12;
	localparam logic [4:0] ADDR_LAST = 5'h12;

	localparam int HOUR_12H_BIT = 6;
	localparam int HOUR_PM_BIT = 5;
	localparam int MONTH_CENTURY_BIT = 7;
	localparam int ALARM_MASK_BIT = 7;
	localparam int ALARM_DYDT_BIT = 6;
	localparam int CTRL_IRQ_OR_SQUARE_SELECT_BIT = 2;
	localparam int CTRL_SECOND_ALARM_IRQ_ENABLE_BIT = 1;
	localparam int CTRL_FIRST_ALARM_IRQ_ENABLE_BIT = 0;
	localparam int STAT_OSF_BIT = 7;
	localparam int STAT_EN32_BIT = 3;
	localparam int STAT_A2F_BIT = 1;
	localparam int STAT_A1F_BIT = 0;

	localparam logic [7:0] MASK_SEC = 8'h7F;
	localparam logic [7:0] MASK_HOUR = 8'h7F;
	localparam logic [7:0] MASK_WDAY = 8'h07;
	localparam logic [7:0] MASK_DATE = 8'h3F;
	localparam logic [7:0] MASK_MONTH = 8'h9F;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] wday;
		logic [7:0] date;
		logic [7:0] month;
		logic [7:0] year;
	} bca_time_t;

	localparam bca_time_t TIME_RESET = '{sec: 8'h00, min: 8'h00, hour: 8'h00,
		wday: 8'h01, date: 8'h01, month: 8'h01, year: 8'h00};
	localparam logic [7:0] CTRL_RESET = 8'h1C;
	localparam logic [7:0] ALARM_RESET = 8'h00;
	localparam logic [7:0] AGING_RESET = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACK_ADDR = 3'b010,
		ST_WR = 3'b011,
		ST_ACK_WR = 3'b100,
		ST_RD = 3'b101,
		ST_ACK_RD = 3'b110
	} bca_state_t;

	localparam longint SECOND_NS = 1000000000;
	localparam longint CLK_PERIOD_NS = 50;
	localparam int SUBSEC_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

// [verif/bca_regs_checker.sv]
// Purpose: Port-level checks of the calendar and alarm register core.
// Assumes: Host runs scl phases of at least eight clock cycles.
// Notes: Only wire timing and the alarm pin are visible here.
`timescale 1ns/1ps
`default_nettype none
module bca_regs_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic irq_square_output_n
);
	logic scl_q;
	logic [3:0] since_fall;
	// The device answers a few cycles after scl falls, through its synchronizers.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q <= 1'b0;
			since_fall <= 4'hF;
		end else begin
			scl_q <= scl_in;
			if (scl_q && !scl_in) begin
				since_fall <= 4'h0;
			end else if (since_fall != 4'hF) begin
				since_fall <= since_fall + 4'h1;
			end
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_start;
		scl_in && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence
	property p_sda_zero;
		sda_o == 1'b0;
	endproperty
	a_sda_zero: assert property (p_sda_zero) else $error("sda drive value not zero");
	property p_release;
		$rose(resetn) |-> !sda_oe && irq_square_output_n;
	endproperty
	a_release: assert property (p_release) else $error("pins busy after reset");
	property p_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("sda changed while scl high");
	property p_lag;
		$changed(sda_oe) |-> since_fall inside {[1:6]};
	endproperty
	a_lag: assert property (p_lag) else $error("sda change not tied to scl fall");
	property p_ack_hold;
		$rose(sda_oe) |=> sda_oe [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda low too short");
	property p_start_quiet;
		s_start |-> !sda_oe [*8];
	endproperty
	a_start_quiet: assert property (p_start_quiet) else $error("sda driven after start");
	property p_stop_quiet;
		s_stop |=> !sda_oe [*8];
	endproperty
	a_stop_quiet: assert property (p_stop_quiet) else $error("sda driven after stop");
	property p_irq_low_hold;
		$fell(irq_square_output_n) |-> !irq_square_output_n [*8];
	endproperty
	a_irq_low_hold: assert property (p_irq_low_hold) else $error("alarm pin low too short");
	property p_irq_high_hold;
		$rose(irq_square_output_n) |-> irq_square_output_n [*4];
	endproperty
	a_irq_high_hold: assert property (p_irq_high_hold) else $error("alarm pin glitch");
endmodule // bca_regs_checker
bind bca_calendar_alarm_regs bca_regs_checker bca_regs_checker_i (
	.sys_clk(sys_clk),
	.resetn(resetn),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_o(sda_o),
	.sda_oe(sda_oe),
	.irq_square_output_n(irq_square_output_n)
);
`default_nettype wire

// [verif/bca_host_model.sv]
// Purpose: I2C master standing in for the host microcontroller.
// Assumes: The wire is resolved outside; sda_low pulls the line down.
// Notes: Sda moves two cycles after scl falls so no false START is seen.
`timescale 1ns/1ps
`default_nettype none
module bca_host_model #(
	parameter int PH = 10
) (
	input wire logic sys_clk,
	input wire logic sda_line,
	output var logic scl,
	output var logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic bit_io(input logic b, output logic seen);
		sda_low <= !b;
		hold(PH);
		scl <= 1'b1;
		hold(PH);
		seen = sda_line;
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		hold(PH);
		scl <= 1'b1;
		hold(PH);
		sda_low <= 1'b1;
		hold(PH);
		scl <= 1'b0;
		hold(2);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		hold(PH);
		scl <= 1'b1;
		hold(PH);
		sda_low <= 1'b0;
		hold(PH);
	endtask
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
	endtask
endmodule // bca_host_model
`default_nettype wire

// [verif/bca_calendar_alarm_regs_bench.sv]
// Purpose: Self-checking bench for the calendar and alarm register core.
// Assumes: One tick every SUB cycles, far shorter than a real second.
// Notes: Waits are fixed counts sized from SUB and the byte time.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module bca_calendar_alarm_regs_bench;
	localparam int SUB = 8000;
	localparam logic [6:0] SA = 7'h5A;
	logic sys_clk;
	logic resetn;
	logic scl;
	logic sda_low;
	logic sda_line;
	logic sda_o;
	logic sda_oe;
	logic irq_n;
	int error_cnt = 0;
	int n_compared = 0;
	assign sda_line = !(sda_low || sda_oe);
	bca_calendar_alarm_regs #(.SLAVE_ADDR(SA), .SUBSEC_CYCLES(SUB)) bca_calendar_alarm_regs_i (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.scl_in(scl),
		.sda_in(sda_line),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.irq_square_output_n(irq_n)
	);
	bca_host_model bca_host_model_i (
		.sys_clk(sys_clk),
		.sda_line(sda_line),
		.scl(scl),
		.sda_low(sda_low)
	);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		logic a;
		bca_host_model_i.start();
		bca_host_model_i.wbyte({SA, 1'b0}, a);
		`CHK("address ack", 1'b1, a)
		bca_host_model_i.wbyte(ptr, a);
		foreach (d[i]) begin
			bca_host_model_i.wbyte(d[i], a);
			`CHK("data ack", 1'b1, a)
		end
		bca_host_model_i.stop();
	endtask
	task automatic chk_rd(input logic [7:0] ptr, input logic [7:0] e[$]);
		logic a;
		logic [7:0] b;
		bca_host_model_i.start();
		bca_host_model_i.wbyte({SA, 1'b0}, a);
		bca_host_model_i.wbyte(ptr, a);
		bca_host_model_i.start();
		bca_host_model_i.wbyte({SA, 1'b1}, a);
		foreach (e[i]) begin
			bca_host_model_i.rbyte(i == e.size() - 1, b);
			`CHK("read byte", e[i], b)
		end
		bca_host_model_i.stop();
	endtask
	// Sets a legal time in one burst, well inside one tick, then reads after the carry.
	task automatic roll(input logic [7:0] w[$], input logic [7:0] e[$]);
		wr(8'h00, w);
		hold(SUB - 500);
		chk_rd(8'h00, e);
	endtask
	initial begin
		logic a;
		resetn = 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		hold(3);
		chk_rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h1C, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00});
		bca_host_model_i.start();
		bca_host_model_i.wbyte(8'h20, a);
		`CHK("foreign address ack", 1'b0, a)
		bca_host_model_i.stop();
		wr(8'h11, '{8'h55});
		chk_rd(8'h11, '{8'h00});
		wr(8'h12, '{8'hAA, 8'h10});
		chk_rd(8'h00, '{8'h10});
		hold(3000);
		wr(8'h00, '{8'h20});
		hold(5000);
		chk_rd(8'h00, '{8'h20});
		// Weekday numbering is consecutive, so 7 wraps to 1.
		roll('{8'h59, 8'h59, 8'h71, 8'h07, 8'h28, 8'h02, 8'h99},
			'{8'h00, 8'h00, 8'h52, 8'h01, 8'h01, 8'h03, 8'h99});
		roll('{8'h59, 8'h59, 8'h51, 8'h02, 8'h15, 8'h06, 8'h10},
			'{8'h00, 8'h00, 8'h72, 8'h02, 8'h15, 8'h06, 8'h10});
		roll('{8'h59, 8'h59, 8'h23, 8'h03, 8'h31, 8'h12, 8'h99},
			'{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h81, 8'h00});
		roll('{8'h59, 8'h59, 8'h23, 8'h05, 8'h28, 8'h02, 8'h04},
			'{8'h00, 8'h00, 8'h00, 8'h06, 8'h29, 8'h02, 8'h04});
		wr(8'h07, '{8'h80, 8'h80, 8'h80, 8'h80, 8'h01, 8'h80, 8'h80, 8'h04});
		wr(8'h00, '{8'h59, 8'h00});
		wr(8'h0F, '{8'h88});
		hold(SUB);
		`CHK("alarm pin without enables", 1'b1, irq_n)
		chk_rd(8'h0F, '{8'h8B});
		wr(8'h0E, '{8'h06});
		`CHK("alarm pin with second enable", 1'b0, irq_n)
		wr(8'h0F, '{8'h89});
		`CHK("alarm pin after clear", 1'b1, irq_n)
		chk_rd(8'h0F, '{8'h89});
		// Square mode with alarm one enabled and flagged: the pin must ignore the flag.
		wr(8'h0E, '{8'h01});
		wr(8'h00, '{8'h00});
		`CHK("square pin first half", 1'b1, irq_n)
		hold(SUB / 2);
		`CHK("square pin second half", 1'b0, irq_n)
		hold(SUB / 2);
		`CHK("square pin next second", 1'b1, irq_n)
		close_out();
	end
endmodule // bca_calendar_alarm_regs_bench
`default_nettype wire
